// ===== src/agcm_consts.svh
/*
 constants for the acquisition gate and channel map block.
 assumes inclusion by bare name from design files and the bench.
*/
`ifndef AGCM_CONSTS_SVH
`define AGCM_CONSTS_SVH
`define AGCM_CH_AUX_ONE 4'h3
`define AGCM_CH_AUX_TWO 4'h4
`define AGCM_CH_AUX_THREE 4'h5
`define AGCM_CH_BAT_ONE 4'h6
`define AGCM_CH_BAT_TWO 4'h7
`define AGCM_CH_DLOW 4'h8
`define AGCM_CH_DHIGH 4'h9
`define AGCM_CH_PLATE_A 4'hA
`define AGCM_CH_PLATE_B 4'h2
`define AGCM_RA_PLATE_A 5'h1A
`define AGCM_RA_PLATE_B 5'h12
`define AGCM_RA_DLOW 5'h18
`define AGCM_RA_DHIGH 5'h19
`define AGCM_RA_AUX_ONE 5'h13
`define AGCM_RA_AUX_TWO 5'h14
`define AGCM_RA_AUX_THREE 5'h15
`define AGCM_RA_BAT_ONE 5'h16
`define AGCM_RA_BAT_TWO 5'h17
`define AGCM_CTRL2_ADDR 5'h02
`define AGCM_POLARITY_BIT 3
`define AGCM_POLARITY_RST 1'b0
`define AGCM_CH_LSB 7
`define AGCM_CH_MSB 10
`define AGCM_ACQ_NS 400
`define AGCM_ACQ_CYC (((`AGCM_ACQ_NS) + 4) / 5)
`define AGCM_CONV_CYC 16
`endif

// ===== src/agcm_pkg.sv
/*
 types for the acquisition gate and channel map block.
 assumes the constants header sits beside it.
*/
package agcm_pkg;
   typedef enum logic [4:0] {
      AGCM_IDLE = 5'b0_0001,
      AGCM_DELAY = 5'b0_0010,
      AGCM_ACQ = 5'b0_0100,
      AGCM_WAIT = 5'b0_1000,
      AGCM_CONV = 5'b1_0000
   } agcm_state_e;
   typedef struct packed {
      logic [3:0] plate_sw;
      logic bias_low;
      logic bias_high;
      logic [4:0] addr;
      logic lim_chk;
      logic valid;
   } agcm_map_s;
   typedef struct packed {
      logic [11:0] data;
      logic [4:0] addr;
      logic we;
   } agcm_res_s;
endpackage

// ===== src/agcm_chan_map.sv
/*
 channel code to switch setting and result address decode.
 assumes a 4-bit code from the control register channel field.
*/
`timescale 1ns/1ps
`include "agcm_consts.svh"
module agcm_chan_map (
   input wire logic [3:0] code,
   output agcm_pkg::agcm_map_s map
);
   import agcm_pkg::*;
   wire is_pa = (code == `AGCM_CH_PLATE_A);
   wire is_pb = (code == `AGCM_CH_PLATE_B);
   wire is_dl = (code == `AGCM_CH_DLOW);
   wire is_dh = (code == `AGCM_CH_DHIGH);
   wire is_aux = (code >= `AGCM_CH_AUX_ONE) && (code <= `AGCM_CH_BAT_TWO);
   wire [4:0] addr_w;
   assign addr_w = is_pa ? `AGCM_RA_PLATE_A :
                   is_pb ? `AGCM_RA_PLATE_B :
                   is_dl ? `AGCM_RA_DLOW :
                   is_dh ? `AGCM_RA_DHIGH :
                   {1'b1, code};
   assign map.plate_sw = is_pa ? 4'b0101 : is_pb ? 4'b0110 : 4'b0000;
   assign map.bias_low = is_dl;
   assign map.bias_high = is_dh;
   assign map.addr = addr_w;
   assign map.lim_chk = is_dl || (code == `AGCM_CH_AUX_ONE) || (code == `AGCM_CH_BAT_ONE) ||
                        (code == `AGCM_CH_BAT_TWO);
   assign map.valid = is_pa | is_pb | is_dl | is_dh | is_aux;
endmodule

// ===== src/agcm_top.sv
/*
 acquisition gate, halt polarity and result storage for the converter.
 assumes the analog side presents a 12-bit code when conversion ends.
*/
`timescale 1ns/1ps
`include "agcm_consts.svh"
// What this block does
// - plate code A maps to address 11010b
// - plate code B maps to address 10010b
// - no sampling starts while halt active
// - halt during sampling restarts sampling afterwards
// - polarity is bit 3 of register 02h
// - polarity one high, zero low, resets zero
// - halt ignored in conversion and first delay
// - halt gating covers every input channel
// - diode low and high bias on 1000b/1001b
// - diode results at 11000b and 11001b
// - high bias uses multiple of low current
// - limit check uses low-bias diode result
// - single mode converts control bits 10:7
// - monitored results compared against both limits
module agcm_top (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic acq_halt_input,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [11:0] wr_data,
   input wire logic start,
   input wire logic [7:0] delay_cyc,
   input wire logic [11:0] lim_high,
   input wire logic [11:0] lim_low,
   input wire logic [11:0] adc_code,
   output agcm_pkg::agcm_res_s result,
   output logic [3:0] plate_sw,
   output logic bias_low,
   output logic bias_high,
   output logic sampling,
   output logic out_of_limit,
   output logic busy
);
   import agcm_pkg::*;
   logic [11:0] ctrl1_reg;
   logic [11:0] ctrl2_reg;
   logic halt_s1_reg;
   logic halt_s2_reg;
   agcm_state_e state_reg;
   agcm_state_e state_next;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   agcm_map_s map;
   agcm_res_s result_next;
   logic ool_next;
   wire [3:0] chan_code = ctrl1_reg[`AGCM_CH_MSB:`AGCM_CH_LSB];
   wire halt_polarity = ctrl2_reg[`AGCM_POLARITY_BIT];
   wire halt_act = halt_polarity ? halt_s2_reg : ~halt_s2_reg;
   wire cnt_done = (cnt_reg == 8'h00);

   agcm_chan_map u_map (
      .code(chan_code),
      .map(map)
   );

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         halt_s1_reg <= 1'b0;
         halt_s2_reg <= 1'b0;
      end else begin
         halt_s1_reg <= acq_halt_input;
         halt_s2_reg <= halt_s1_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl1_reg <= 12'h000;
         ctrl2_reg <= {11'h000, `AGCM_POLARITY_RST};
      end else if (wr_en) begin
         if (wr_addr == 5'h01) begin
            ctrl1_reg <= wr_data;
         end else if (wr_addr == `AGCM_CTRL2_ADDR) begin
            ctrl2_reg <= wr_data;
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         AGCM_IDLE: begin
            if (start && map.valid) begin
               state_next = AGCM_DELAY;
               cnt_next = delay_cyc;
            end
         end
         AGCM_DELAY: begin
            if (cnt_done) begin
               state_next = AGCM_WAIT;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         AGCM_WAIT: begin
            if (!halt_act) begin
               state_next = AGCM_ACQ;
               cnt_next = 8'(`AGCM_ACQ_CYC - 1);
            end
         end
         AGCM_ACQ: begin
            if (halt_act) begin
               state_next = AGCM_WAIT;
            end else if (cnt_done) begin
               state_next = AGCM_CONV;
               cnt_next = 8'(`AGCM_CONV_CYC - 1);
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         AGCM_CONV: begin
            if (cnt_done) begin
               state_next = AGCM_IDLE;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         default: begin
            state_next = AGCM_IDLE;
         end
      endcase
   end

   wire conv_end = (state_reg == AGCM_CONV) && cnt_done;
   wire oor = (adc_code > lim_high) || (adc_code < lim_low);
   assign result_next.data = adc_code;
   assign result_next.addr = map.addr;
   assign result_next.we = conv_end;
   assign ool_next = (conv_end && map.lim_chk) ? oor : out_of_limit;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg <= AGCM_IDLE;
         cnt_reg <= 8'h00;
         result <= '0;
         plate_sw <= 4'h0;
         bias_low <= 1'b0;
         bias_high <= 1'b0;
         sampling <= 1'b0;
         out_of_limit <= 1'b0;
         busy <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         result <= result_next;
         plate_sw <= map.plate_sw;
         bias_low <= map.bias_low && (state_next != AGCM_IDLE);
         bias_high <= map.bias_high && (state_next != AGCM_IDLE);
         sampling <= (state_next == AGCM_ACQ);
         out_of_limit <= ool_next;
         busy <= (state_next != AGCM_IDLE);
      end
   end

   AST_NO_START_HALTED: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == AGCM_WAIT && halt_act) |=> state_reg != AGCM_ACQ)
      else $error("sampling began while halt active");
   AST_ABORT: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == AGCM_ACQ && halt_act) |=> state_reg == AGCM_WAIT)
      else $error("sampling not abandoned on halt");
   AST_RESTART: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == AGCM_WAIT && !halt_act) |=> (state_reg == AGCM_ACQ &&
      cnt_reg == 8'(`AGCM_ACQ_CYC - 1)))
      else $error("sampling did not restart from start");
   AST_CONV_IGNORES: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == AGCM_CONV && !cnt_done) |=> state_reg == AGCM_CONV)
      else $error("conversion disturbed");
   AST_DELAY_IGNORES: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == AGCM_DELAY && !cnt_done) |=> state_reg == AGCM_DELAY)
      else $error("first delay disturbed");
   AST_POLARITY_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!halt_polarity && !halt_s2_reg) |-> halt_act)
      else $error("polarity zero not active low");
   AST_SYNC: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(nrst, 2) |-> halt_s2_reg == $past(acq_halt_input, 2))
      else $error("synchroniser depth wrong");
   AST_PLATE_A: assert property (@(posedge clk_sys) disable iff (!nrst)
      (conv_end && chan_code == `AGCM_CH_PLATE_A) |=>
      (result.we && result.addr == `AGCM_RA_PLATE_A))
      else $error("plate A address wrong");
   AST_PLATE_B: assert property (@(posedge clk_sys) disable iff (!nrst)
      (conv_end && chan_code == `AGCM_CH_PLATE_B) |=>
      (result.we && result.addr == `AGCM_RA_PLATE_B))
      else $error("plate B address wrong");
   AST_DIODE: assert property (@(posedge clk_sys) disable iff (!nrst)
      (conv_end && chan_code == `AGCM_CH_DHIGH) |=> result.addr == `AGCM_RA_DHIGH)
      else $error("diode high address wrong");
   AST_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
      (conv_end && chan_code == `AGCM_CH_DLOW && adc_code > lim_high) |=> out_of_limit)
      else $error("limit not flagged");
endmodule

// ===== test/agcm_lcd_model.sv
/*
 lcd timing partner driving the noisy-period level.
 assumes the bench sets the polarity it has written to ctrl2.
*/
`timescale 1ns/1ps
module agcm_lcd_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic en,
   input wire logic polarity,
   output logic halt
);
   int phase;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase <= 0;
         halt <= 1'b1;
      end else begin
         phase <= (phase + 1) % 150;
         if (en && phase < 20) begin
            halt <= polarity;
         end else begin
            halt <= ~polarity; // steady inactive level when unused
         end
      end
   end
endmodule

// ===== test/tb_top.sv
/*
 self-checking bench for the acquisition gate and channel map.
 assumes the constants header and the lcd partner model.
*/
`timescale 1ns/1ps
`include "agcm_consts.svh"
module tb_top;
   import agcm_pkg::*;
   logic clk_sys = 0, nrst = 0, halt, en = 0, polarity_v = 0, wr_en = 0, start = 0;
   logic [4:0] wr_addr = 0;
   logic [11:0] wr_data = 0, lim_high = 0, lim_low = 0, adc_code = 0;
   logic [7:0] delay_cyc = 0;
   logic [3:0] plate_sw;
   logic bias_low, bias_high, sampling, out_of_limit, busy;
   agcm_res_s result;
   int failures = 0, checks_done = 0, seed = 32'h30174909;
   int run = 0, last_run = 0, gap = 0, got_gap = 0, we_cnt = 0, ref_gap = -1;
   logic [3:0] sw_snap;
   logic bl_snap, bh_snap;
   logic [4:0] hist = 0;
   int exp_q[$];
   agcm_lcd_model agcm_lcd_model_i (.clk_sys(clk_sys), .nrst(nrst), .en(en),
      .polarity(polarity_v),
      .halt(halt));
   agcm_top agcm_top_i (.clk_sys(clk_sys), .nrst(nrst), .acq_halt_input(halt), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .start(start), .delay_cyc(delay_cyc),
      .lim_high(lim_high), .lim_low(lim_low), .adc_code(adc_code), .result(result),
      .plate_sw(plate_sw), .bias_low(bias_low), .bias_high(bias_high), .sampling(sampling),
      .out_of_limit(out_of_limit), .busy(busy));
   always #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      checks_done++;
      if (seen !== expv) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic give_verdict();
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      hist <= {hist[3:0], halt === polarity_v};
      if (sampling === 1'b1) begin
         run <= run + 1;
         gap <= 0;
         sw_snap <= plate_sw;
         bl_snap <= bias_low;
         bh_snap <= bias_high;
         if (&hist) chk(sampling, 0); // no sampling in noisy period
      end else begin
         if (run != 0) last_run <= run;
         run <= 0;
         gap <= gap + 1;
      end
      if (result.we === 1'b1) begin
         got_gap <= gap;
         we_cnt <= we_cnt + 1;
      end
   end
   task automatic wr(input logic [4:0] a, input logic [11:0] d);
      @(posedge clk_sys);
      wr_en <= 1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 0;
   endtask
   task automatic run_one(input logic [3:0] code, input logic noisy, inout int oor);
      int n, ea;
      logic [11:0] d;
      d = $random(seed);
      en <= noisy;
      adc_code <= d;
      lim_high <= $random(seed);
      lim_low <= $random(seed);
      delay_cyc <= $random(seed) & 8'h1F;
      wr(5'h01, {1'b0, code, 7'h00}); // channel field bits 10:7
      case (code)
         4'hA: ea = 'h1A;
         4'h2: ea = 'h12;
         4'h8: ea = 'h18;
         4'h9: ea = 'h19;
         default: ea = {1'b1, code};
      endcase
      exp_q.push_back(ea);
      n = we_cnt;
      @(posedge clk_sys);
      start <= 1;
      @(posedge clk_sys);
      start <= 0;
      @(posedge clk_sys);
      chk(busy, 1); // busy once start taken
      for (int i = 0; i < 3000 && we_cnt == n; i++) @(posedge clk_sys);
      if (we_cnt == n) failures++;
      @(posedge clk_sys);
      chk(busy, 0); // busy ends with conversion
      if (code == 3 || code == 6 || code == 7 || code == 8) begin
         oor = (d > lim_high) || (d < lim_low);
      end
      chk(result.addr, exp_q.pop_front()); // result addresses
      chk(result.data, d);
      chk(out_of_limit, oor); // limit check on monitored results
      chk(sw_snap, code == 4'hA ? 5 : code == 4'h2 ? 6 : 0); // plate switches
      chk({bl_snap, bh_snap}, {code == 4'h8, code == 4'h9}); // diode bias
      chk(last_run, `AGCM_ACQ_CYC); // full restart after abort
      if (ref_gap < 0) ref_gap = got_gap;
      chk(got_gap, ref_gap); // halt ignored in conversion
   endtask
   initial begin
      int oor;
      oor = 0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1;
      for (int p = 0; p < 2; p++) begin
         en <= 0;
         polarity_v <= p;
         if (p == 1) wr(5'h02, 12'h008); // polarity bit 3 of 02h
         for (int c = 2; c <= 10; c++) begin
            run_one(c, c[0] ^ p[0], oor); // reset polarity 0 on first pass
            run_one(c, 1, oor);
         end
      end
      give_verdict();
   end
   initial begin
      #400us;
      failures++;
      give_verdict();
   end
endmodule
